// File: irq_ctrl_pkg.sv
package irq_ctrl_pkg;
    localparam logic [7:0] irq_control_offset = 8'h0b;
    localparam logic [7:0] irq_control_reset = 8'h00;
    localparam int global_enable_bit = 0;
    localparam int enable_base_bit = 1;
    localparam int flag_base_bit = 4;
    localparam int unused_bit = 7;
    localparam int num_sources = 3;
    localparam logic [7:0] usb_vector = 8'h04;
    localparam logic [7:0] timer0_vector = 8'h08;
    localparam logic [7:0] timer1_vector = 8'h0c;
    localparam logic [4:0] usb_ctrl_reset = 5'h00;
    localparam int suspend_bit = 0;
    localparam int resume_bit = 3;
    localparam int bus_reset_bit = 4;
    localparam int fifo_count = 4;
    localparam logic [3:0] fifo_req_reset = 4'h0;
endpackage : irq_ctrl_pkg

// File: mcu_three_source_irq_ctrl.sv
// Functional notes
// - taking an interrupt clears global enable
// - re-enabling inside service allows nesting
// - full stack withholds acknowledge, flag kept
// - every source can wake from halt
// - acknowledge pushes program counter only
// - four usb events set usb flag
// - usb calls 04h, clears flag, enable
// - fifo access sets its request bit
// - suspend sets status bit0, raises usb
// - resume sets status bit3, raises usb
// - bus reset sets flag, firmware clears
// - timer0 overflow sets bit5, calls 08h
// - timer1 overflow sets bit6, calls 0ch
// - control register layout, bit7 reads zero
// - acknowledges held until reenabled or irq return
// - irq return sets enable, plain return not
// - requests serviced at next final phase edge
// - fixed priority usb, timer0, timer1
// - flags stay until serviced or cleared
// - flag already set blocks its wake
`timescale 1ns/1ps
`default_nettype none
module mcu_three_source_irq_ctrl (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_clock_enable,
    input wire logic i_final_clock_phase,
    input wire logic i_stack_full,
    input wire logic i_irq_exit_instr,
    input wire logic i_halt_enter,
    input wire logic i_halted,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [3:0] i_fifo_access,
    input wire logic i_usb_suspend,
    input wire logic i_usb_resume,
    input wire logic i_usb_bus_reset,
    input wire logic [3:0] i_fifo_req_clear,
    input wire logic i_bus_reset_clear,
    input wire logic i_timer0_overflow,
    input wire logic i_timer1_overflow,
    output logic [7:0] o_reg_rdata,
    output logic o_irq_ack,
    output logic [7:0] o_irq_vector,
    output logic o_push_pc,
    output logic o_wake,
    output logic [3:0] o_usb_fifo_request_reg,
    output logic [4:0] o_usb_control_status_reg
);
    logic [7:0] irq_control_reg;
    logic [7:0] next_irq_control;
    logic [3:0] usb_fifo_request_reg;
    logic [3:0] next_fifo_req;
    logic [4:0] usb_control_status_reg;
    logic [4:0] next_usb_ctrl;
    logic [2:0] wake_block;
    logic [2:0] next_wake_block;
    logic [7:0] reg_rdata;
    logic [7:0] next_reg_rdata;
    logic irq_ack;
    logic next_irq_ack;
    logic [7:0] irq_vector;
    logic [7:0] next_irq_vector;
    logic wake;
    logic next_wake;
    logic [2:0] raw_event;
    logic [2:0] eligible;
    logic [2:0] grant;
    logic ctrl_write;
    logic usb_event;

    assign ctrl_write = i_reg_write && (i_reg_addr == irq_ctrl_pkg::irq_control_offset);

    // usb status and fifo request bits
    always_comb begin
        next_fifo_req = (usb_fifo_request_reg & ~i_fifo_req_clear) | i_fifo_access;
        next_usb_ctrl = usb_control_status_reg;
        if (i_usb_suspend) begin
            next_usb_ctrl[irq_ctrl_pkg::suspend_bit] = 1'b1;
        end
        if (i_usb_resume) begin
            next_usb_ctrl[irq_ctrl_pkg::resume_bit] = 1'b1;
        end
        // set wins over a firmware clear in the same cycle
        if (i_usb_bus_reset) begin
            next_usb_ctrl[irq_ctrl_pkg::bus_reset_bit] = 1'b1;
        end else if (i_bus_reset_clear) begin
            next_usb_ctrl[irq_ctrl_pkg::bus_reset_bit] = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            usb_fifo_request_reg <= irq_ctrl_pkg::fifo_req_reset;
            usb_control_status_reg <= irq_ctrl_pkg::usb_ctrl_reset;
        end else if (i_clock_enable) begin
            usb_fifo_request_reg <= next_fifo_req;
            usb_control_status_reg <= next_usb_ctrl;
        end
    end

    chk_resume_sets: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_usb_resume) |=> o_usb_control_status_reg[irq_ctrl_pkg::resume_bit]
            && irq_control_reg[irq_ctrl_pkg::flag_base_bit])
        else $error("resume not recorded");
    chk_bus_reset_sets: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_usb_bus_reset) |=> o_usb_control_status_reg[irq_ctrl_pkg::bus_reset_bit]
            && irq_control_reg[irq_ctrl_pkg::flag_base_bit])
        else $error("bus reset not recorded");
    chk_bus_reset_clears: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_bus_reset_clear && !i_usb_bus_reset)
            |=> !o_usb_control_status_reg[irq_ctrl_pkg::bus_reset_bit])
        else $error("bus reset flag not cleared");
    // one check per endpoint fifo
    for (genvar k = 0; k < irq_ctrl_pkg::fifo_count; k++) begin : g_fifo_chk
        chk_fifo_sets_bit: assert property (@(posedge i_clock) disable iff (!i_resetn)
            (i_clock_enable && i_fifo_access[k]) |=> o_usb_fifo_request_reg[k]
                && irq_control_reg[irq_ctrl_pkg::flag_base_bit])
            else $error("fifo request not recorded");
    end

    assign usb_event = (|i_fifo_access) | i_usb_suspend | i_usb_resume | i_usb_bus_reset;
    assign raw_event = {i_timer1_overflow, i_timer0_overflow, usb_event};

    // a source is eligible when its flag, global and own enable are set and stack has room
    always_comb begin
        eligible = '0;
        if (irq_control_reg[irq_ctrl_pkg::global_enable_bit] && !i_stack_full) begin
            eligible = irq_control_reg[irq_ctrl_pkg::enable_base_bit +: 3]
                & irq_control_reg[irq_ctrl_pkg::flag_base_bit +: 3];
        end
        // fixed priority, only one grant per final-phase edge
        grant = '0;
        if (i_final_clock_phase) begin
            if (eligible[0]) begin
                grant = 3'b001;
            end else if (eligible[1]) begin
                grant = 3'b010;
            end else if (eligible[2]) begin
                grant = 3'b100;
            end
        end
    end

    // control register: software write first, then irq-return enable set, then grant clears enable, then flag clear, then flag set
    always_comb begin
        next_irq_control = irq_control_reg;
        if (ctrl_write) begin
            next_irq_control = i_reg_wdata;
        end
        if (i_irq_exit_instr) begin
            next_irq_control[irq_ctrl_pkg::global_enable_bit] = 1'b1;
        end
        if (|grant) begin
            next_irq_control[irq_ctrl_pkg::global_enable_bit] = 1'b0;
        end
        for (int i = 0; i < irq_ctrl_pkg::num_sources; i++) begin
            if (grant[i]) begin
                next_irq_control[irq_ctrl_pkg::flag_base_bit + i] = 1'b0;
            end
            if (raw_event[i]) begin
                next_irq_control[irq_ctrl_pkg::flag_base_bit + i] = 1'b1;
            end
        end
        next_irq_control[irq_ctrl_pkg::unused_bit] = 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_control_reg <= irq_ctrl_pkg::irq_control_reset;
        end else if (i_clock_enable) begin
            irq_control_reg <= next_irq_control;
        end
    end

    // a withheld request must survive until the stack has room again
    chk_full_keeps_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_stack_full && !ctrl_write && irq_control_reg[irq_ctrl_pkg::flag_base_bit + 1])
            |=> irq_control_reg[irq_ctrl_pkg::flag_base_bit + 1])
        else $error("flag lost while stack full");

    // wake blocking: flags already set on halt entry cannot wake
    always_comb begin
        next_wake_block = wake_block;
        if (i_halt_enter) begin
            next_wake_block = irq_control_reg[irq_ctrl_pkg::flag_base_bit +: 3];
        end
        next_wake = i_halted && (|(raw_event & ~wake_block));
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_block <= '0;
            wake <= 1'b0;
        end else if (i_clock_enable) begin
            wake_block <= next_wake_block;
            wake <= next_wake;
        end
    end

    chk_wake_blocked: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_halted && wake_block[0] && (raw_event == 3'b001)) |=> !o_wake)
        else $error("blocked source woke the device");
    chk_wake_on_event: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_halted && (|(raw_event & ~wake_block))) |=> o_wake)
        else $error("wake missing");

    // acknowledge pulse with vector; core pushes only the program counter
    always_comb begin
        next_irq_ack = |grant;
        next_irq_vector = irq_vector;
        if (grant[0]) begin
            next_irq_vector = irq_ctrl_pkg::usb_vector;
        end else if (grant[1]) begin
            next_irq_vector = irq_ctrl_pkg::timer0_vector;
        end else if (grant[2]) begin
            next_irq_vector = irq_ctrl_pkg::timer1_vector;
        end
        next_reg_rdata = reg_rdata;
        if (i_reg_read) begin
            next_reg_rdata = (i_reg_addr == irq_ctrl_pkg::irq_control_offset) ? irq_control_reg : 8'h00;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_ack <= 1'b0;
            irq_vector <= 8'h00;
            reg_rdata <= 8'h00;
        end else if (i_clock_enable) begin
            irq_ack <= next_irq_ack;
            irq_vector <= next_irq_vector;
            reg_rdata <= next_reg_rdata;
        end
    end

    assign o_irq_ack = irq_ack;
    assign o_push_pc = irq_ack;
    assign o_irq_vector = irq_vector;
    assign o_wake = wake;
    assign o_reg_rdata = reg_rdata;
    assign o_usb_fifo_request_reg = usb_fifo_request_reg;
    assign o_usb_control_status_reg = usb_control_status_reg;

    sequence ack_cause_s;
        i_clock_enable && i_final_clock_phase && (|eligible);
    endsequence

    chk_ack_follows_eligible: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ack_cause_s |=> o_irq_ack)
        else $error("acknowledge missing after eligible request");
    chk_ack_clears_global: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ack_cause_s |=> !irq_control_reg[0])
        else $error("global enable not cleared on acknowledge");
    chk_stack_full_holds: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_stack_full) |=> !o_irq_ack)
        else $error("acknowledge while stack full");
    chk_usb_priority_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (ack_cause_s and eligible[0]) |=> (o_irq_vector == 8'h04))
        else $error("usb not given priority");
    chk_timer0_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (ack_cause_s and (eligible[1:0] == 2'b10)) |=> (o_irq_vector == 8'h08))
        else $error("timer0 vector wrong");
    chk_timer1_vector: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (ack_cause_s and (eligible == 3'b100)) |=> (o_irq_vector == 8'h0c))
        else $error("timer1 vector wrong");
    chk_bit7_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !irq_control_reg[7])
        else $error("unused bit set");
    chk_exit_sets_enable: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_irq_exit_instr && !(|grant)) |=> irq_control_reg[0])
        else $error("irq return did not set enable");
    chk_flag_set_wins: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_timer0_overflow) |=> irq_control_reg[5])
        else $error("timer0 flag lost");
    chk_suspend_sets: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && i_usb_suspend) |=> o_usb_control_status_reg[0] && irq_control_reg[4])
        else $error("suspend not recorded");

    sequence usb_win_s;
        ack_cause_s ##0 eligible[0];
    endsequence
    sequence timer0_win_s;
        ack_cause_s ##0 (eligible[1:0] == 2'b10);
    endsequence
    sequence timer1_win_s;
        ack_cause_s ##0 (eligible == 3'b100);
    endsequence

    chk_usb_flag_cleared: assert property (@(posedge i_clock) disable iff (!i_resetn)
        usb_win_s ##0 !usb_event |=> !irq_control_reg[irq_ctrl_pkg::flag_base_bit])
        else $error("usb flag not cleared on acknowledge");
    chk_timer0_flag_cleared: assert property (@(posedge i_clock) disable iff (!i_resetn)
        timer0_win_s ##0 !i_timer0_overflow |=> !irq_control_reg[irq_ctrl_pkg::flag_base_bit + 1])
        else $error("timer0 flag not cleared on acknowledge");
    chk_timer1_flag_cleared: assert property (@(posedge i_clock) disable iff (!i_resetn)
        timer1_win_s ##0 !i_timer1_overflow |=> !irq_control_reg[irq_ctrl_pkg::flag_base_bit + 2])
        else $error("timer1 flag not cleared on acknowledge");
    chk_lower_flag_kept: assert property (@(posedge i_clock) disable iff (!i_resetn)
        usb_win_s ##0 (eligible[1] && !ctrl_write) |=> irq_control_reg[irq_ctrl_pkg::flag_base_bit + 1])
        else $error("losing request dropped");
    // one pulse only: the grant itself drops global enable
    chk_ack_single_pulse: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && o_irq_ack) |=> !o_irq_ack)
        else $error("acknowledge longer than one cycle");
    chk_masked_no_ack: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && !irq_control_reg[irq_ctrl_pkg::global_enable_bit]) |=> !o_irq_ack)
        else $error("acknowledge while globally masked");
    chk_ack_only_at_phase: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_clock_enable && !i_final_clock_phase) |=> !o_irq_ack)
        else $error("acknowledge outside final phase");
endmodule : mcu_three_source_irq_ctrl
`default_nettype wire

// File: cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model #(
    parameter int stack_levels = 2,
    parameter int phase_period = 4
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_push,
    input wire logic i_pop,
    output logic o_final_clock_phase,
    output logic o_stack_full
);
    int depth;
    int phase_count;
    // one instruction every phase_period clocks, final phase on its last clock
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            depth <= 0;
            phase_count <= 0;
            o_final_clock_phase <= 1'b0;
        end else begin
            phase_count <= (phase_count + 1) % phase_period;
            o_final_clock_phase <= (phase_count == phase_period - 2);
            if (i_push && !i_pop && depth < stack_levels) depth <= depth + 1;
            else if (i_pop && !i_push && depth > 0) depth <= depth - 1;
        end
    end
    // small stack on purpose so a full stack is reached after two nested services
    assign o_stack_full = (depth == stack_levels);
endmodule : cpu_core_model
`default_nettype wire

// File: mcu_three_source_irq_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_three_source_irq_ctrl_bench;
    logic i_clock = 0, i_resetn = 0, halted = 0, we = 0, re = 0, ce = 1;
    logic [7:0] addr = 0, wdata = 0, ev = 0, rdata, vector;
    logic [3:0] fifo = 0, fifo_clr = 0, fifo_req;
    logic [4:0] usb_status;
    logic phase, full, ack, push, wake;
    int errors = 0, num_checks = 0, acks = 0, wakes = 0;
    always #5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        acks += (ack === 1'b1);
        wakes += (wake === 1'b1);
    end
    cpu_core_model cpu_core_model_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_push(push), .i_pop(ev[5]),
        .o_final_clock_phase(phase), .o_stack_full(full));
    mcu_three_source_irq_ctrl mcu_three_source_irq_ctrl_i (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_clock_enable(ce), .i_final_clock_phase(phase), .i_stack_full(full), .i_irq_exit_instr(ev[5]),
        .i_halt_enter(ev[6]), .i_halted(halted), .i_reg_write(we), .i_reg_read(re), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_fifo_access(fifo), .i_usb_suspend(ev[2]), .i_usb_resume(ev[3]),
        .i_usb_bus_reset(ev[4]), .i_fifo_req_clear(fifo_clr), .i_bus_reset_clear(ev[7]),
        .i_timer0_overflow(ev[0]), .i_timer1_overflow(ev[1]), .o_reg_rdata(rdata), .o_irq_ack(ack),
        .o_irq_vector(vector), .o_push_pc(push), .o_wake(wake), .o_usb_fifo_request_reg(fifo_req),
        .o_usb_control_status_reg(usb_status));
    task tick;
        @(posedge i_clock);
        #1;
    endtask : tick
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task fire(input logic [7:0] m);
        ev = m;
        tick;
        ev = 8'h00;
    endtask : fire
    task wr(input logic [7:0] d);
        addr = 8'h0b;
        wdata = d;
        we = 1;
        tick;
        we = 0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        re = 1;
        tick;
        re = 0;
        chk("read data", exp, rdata);
    endtask : rd
    // polls a bounded number of cycles so a missing acknowledge cannot hang the run
    task wait_ack(input logic [7:0] exp);
        int n;
        n = 0;
        while (ack !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        chk("acknowledge", 8'h01, {7'h00, ack});
        chk("vector", exp, vector);
        chk("push pc", 8'h01, {7'h00, push});
    endtask : wait_ack
    task conclude;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial begin
        #100000;
        errors++;
        conclude;
    end
    initial begin
        repeat (2) @(posedge i_clock);
        #1 i_resetn = 1;
        rd(8'h0b, 8'h00);
        tick;
        rd(8'h0c, 8'h00);
        wr(8'h8e);
        rd(8'h0b, 8'h0e);
        fire(8'h07);
        repeat (8) tick;
        chk("acks masked", 8'h00, acks[7:0]);
        rd(8'h0b, 8'h7e);
        chk("usb status", 8'h01, {3'h0, usb_status});
        wr(8'h7f);
        wait_ack(8'h04);
        rd(8'h0b, 8'h6e);
        fire(8'h20);
        wait_ack(8'h08);
        rd(8'h0b, 8'h4e);
        fire(8'h20);
        wait_ack(8'h0c);
        rd(8'h0b, 8'h0e);
        fire(8'h20);
        rd(8'h0b, 8'h0f);
        fire(8'h01);
        wait_ack(8'h08);
        fire(8'h02);
        wr(8'h4f);
        wait_ack(8'h0c);
        fire(8'h01);
        wr(8'h2f);
        repeat (12) tick;
        chk("acks while full", 8'h05, acks[7:0]);
        rd(8'h0b, 8'h2f);
        fire(8'h20);
        wait_ack(8'h08);
        fire(8'h20);
        tick;
        fire(8'h20);
        wr(8'h0e);
        halted = 1;
        fire(8'h08);
        repeat (3) tick;
        chk("wake", 8'h01, wakes[7:0]);
        chk("usb status", 8'h09, {3'h0, usb_status});
        fire(8'h40);
        tick;
        fire(8'h10);
        repeat (3) tick;
        chk("wake blocked", 8'h01, wakes[7:0]);
        chk("usb status", 8'h19, {3'h0, usb_status});
        fire(8'h02);
        repeat (3) tick;
        chk("wake", 8'h02, wakes[7:0]);
        fire(8'h80);
        chk("usb status", 8'h09, {3'h0, usb_status});
        fifo = 4'h4;
        tick;
        fifo = 4'h0;
        tick;
        chk("fifo request", 8'h04, {4'h0, fifo_req});
        fifo_clr = 4'h4;
        tick;
        fifo_clr = 4'h0;
        tick;
        chk("fifo request", 8'h00, {4'h0, fifo_req});
        // a low clock enable must freeze the flags and the wake output
        ce = 0;
        fire(8'h01);
        ce = 1;
        rd(8'h0b, 8'h5e);
        chk("wake frozen", 8'h02, wakes[7:0]);
        conclude;
    end
endmodule : mcu_three_source_irq_ctrl_bench
`default_nettype wire
